// ==== shared/csync_defs.svh ====
`ifndef CSYNC_DEFS_SVH
`define CSYNC_DEFS_SVH

// external word addresses
`define CSYNC_EXT_SLEEP 8'h03
`define CSYNC_EXT_PIN 8'h04
`define CSYNC_EXT_SOFT 8'h05

// channel register addresses
`define CSYNC_CH_SOFT 8'h81
`define CSYNC_CH_PIN 8'h82
`define CSYNC_CH_START_HOLD 8'h83
`define CSYNC_CH_FREQ_HOLD 8'h84
`define CSYNC_CH_FREQ_LO 8'h85
`define CSYNC_CH_FREQ_HI 8'h86
`define CSYNC_CH_SYNC_SEL 8'h88

// field positions
`define CSYNC_SOFT_START_BIT 4
`define CSYNC_SOFT_HOP_BIT 5
`define CSYNC_PIN_START_BIT 4
`define CSYNC_PIN_HOP_BIT 5
`define CSYNC_PIN_FIRST_BIT 6
`define CSYNC_SEL_LSB 7

// reset values
`define CSYNC_SLEEP_RST 4'hF

// stages between the write acknowledge and the counter trigger
`define CSYNC_SOFT_START_DLY 5
`define CSYNC_SOFT_HOP_DLY 4
// stages between the count of one and the hop counter firing
`define CSYNC_HOP_OUT_DLY 2

`endif

// ==== shared/csync_pkg.sv ====
package csync_pkg;

    typedef enum logic [1:0] {
        CSYNC_IDLE = 2'b01,
        CSYNC_COUNT = 2'b10
    } csync_hold_state_t;

endpackage : csync_pkg

// ==== core/csync_holdoff.sv ====
`timescale 1ns/10ps
module csync_holdoff
    import csync_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int OUT_DLY = 0
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_trig,
    input wire logic [CNT_W-1:0] i_preload,
    output logic o_fire
);

    localparam int SR_W = (OUT_DLY > 0) ? OUT_DLY : 1;

    typedef struct packed {
        csync_hold_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [SR_W-1:0] sr;
    } csync_hold_t;

    csync_hold_t r;
    csync_hold_t next_r;
    logic hit;
    logic load;

    always_comb begin
        hit = (r.st == CSYNC_COUNT) && (r.cnt == CNT_W'(1));
        load = i_trig && (i_preload != '0);
        next_r = r;
        next_r.sr = SR_W'({r.sr, hit});
        case (r.st)
            CSYNC_IDLE: begin
                if (load) begin
                    next_r.cnt = i_preload;
                    next_r.st = CSYNC_COUNT;
                end
            end
            CSYNC_COUNT: begin
                if (load) begin
                    next_r.cnt = i_preload;
                end else if (i_trig || hit) begin
                    next_r.st = CSYNC_IDLE;
                end else begin
                    next_r.cnt = r.cnt - CNT_W'(1);
                end
            end
            default: begin
                next_r.st = CSYNC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '{st: CSYNC_IDLE, cnt: '0, sr: '0};
        end else begin
            r <= next_r;
        end
    end

    assign o_fire = (OUT_DLY == 0) ? hit : r.sr[SR_W-1];

endmodule : csync_holdoff

// ==== core/csync_trig.sv ====
`timescale 1ns/10ps
module csync_trig
    import csync_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_pins,
    input wire logic [3:0] i_pin_en,
    input wire logic [1:0] i_sel,
    input wire logic i_start_en,
    input wire logic i_hop_en,
    input wire logic i_first_only,
    output logic o_start_trig,
    output logic o_hop_trig
);

    typedef struct packed {
        logic prev;
        logic caught;
    } csync_trig_t;

    csync_trig_t r;
    csync_trig_t next_r;
    logic sel_pin;
    logic accept;

    always_comb begin
        sel_pin = i_pins[i_sel];
        accept = sel_pin && !r.prev && i_pin_en[i_sel]
            && !(i_first_only && r.caught);
        next_r.prev = sel_pin;
        next_r.caught = i_first_only && (r.caught || accept);
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_start_trig = accept && i_start_en;
    assign o_hop_trig = accept && i_hop_en;

endmodule : csync_trig

// ==== core/csync_top.sv ====
`timescale 1ns/10ps
`include "csync_defs.svh"
module csync_top
    import csync_pkg::*;
#(
    parameter int N_CH = 4,
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ext,
    input wire logic [1:0] i_chan,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_sync_pins,
    output logic o_write_ack_output,
    output logic [31:0] o_rdata,
    output logic [N_CH-1:0] o_sleep,
    output logic [N_CH-1:0] o_ch_active,
    output logic [N_CH*32-1:0] o_nco_freq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [N_CH-1:0] sleep;
        logic [N_CH-1:0] active;
        logic [3:0] pin_en;
        logic [5:0] soft_word;
        logic [N_CH-1:0][1:0] soft_ctl;
        logic [N_CH-1:0][2:0] pin_ctl;
        logic [N_CH-1:0][1:0] sync_sel;
        logic [N_CH-1:0][CNT_W-1:0] start_hold;
        logic [N_CH-1:0][CNT_W-1:0] freq_hold;
        logic [N_CH-1:0][31:0] freq_shadow;
        logic [N_CH-1:0][31:0] freq_work;
        logic ack;
        logic [31:0] rdata;
        logic [N_CH-1:0] ack_start;
        logic [N_CH-1:0] ack_hop;
        logic [N_CH-1:0] pin_start_q;
        logic [N_CH-1:0] pin_hop_q;
        logic [`CSYNC_SOFT_START_DLY-1:0][N_CH-1:0] start_dly;
        logic [`CSYNC_SOFT_HOP_DLY-1:0][N_CH-1:0] hop_dly;
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
    } csync_top_t;

    csync_top_t r;
    csync_top_t next_r;

    logic [N_CH-1:0] pin_start;
    logic [N_CH-1:0] pin_hop;
    logic [N_CH-1:0] start_trig;
    logic [N_CH-1:0] hop_trig;
    logic [N_CH-1:0] start_fire;
    logic [N_CH-1:0] hop_fire;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic ch_hit(
        input logic wr,
        input logic ext,
        input logic [1:0] chan,
        input logic [7:0] addr,
        input int idx,
        input logic [7:0] want
    );
        ch_hit = wr && !ext && (chan == 2'(idx)) && (addr == want);
    endfunction : ch_hit

    function automatic logic ext_hit(
        input logic wr,
        input logic ext,
        input logic [7:0] addr,
        input logic [7:0] want
    );
        ext_hit = wr && ext && (addr == want);
    endfunction : ext_hit

    ////////////////////////////////////////////////////////////////////////
    // per-channel pin trigger and hold-off counters

    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        csync_trig u_trig (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_pins(r.pin_sync),
            .i_pin_en(r.pin_en),
            .i_sel(r.sync_sel[c]),
            .i_start_en(r.pin_ctl[c][0]),
            .i_hop_en(r.pin_ctl[c][1]),
            .i_first_only(r.pin_ctl[c][2]),
            .o_start_trig(pin_start[c]),
            .o_hop_trig(pin_hop[c])
        );

        // soft events arrive late enough that both sources share one counter
        assign start_trig[c] = r.pin_start_q[c]
            || r.start_dly[`CSYNC_SOFT_START_DLY-1][c];
        assign hop_trig[c] = r.pin_hop_q[c]
            || r.hop_dly[`CSYNC_SOFT_HOP_DLY-1][c];

        csync_holdoff #(
            .CNT_W(CNT_W),
            .OUT_DLY(0)
        ) u_start (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_trig(start_trig[c]),
            .i_preload(r.start_hold[c]),
            .o_fire(start_fire[c])
        );

        csync_holdoff #(
            .CNT_W(CNT_W),
            .OUT_DLY(`CSYNC_HOP_OUT_DLY)
        ) u_hop (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_trig(hop_trig[c]),
            .i_preload(r.freq_hold[c]),
            .o_fire(hop_fire[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_r = r;

        // pins pass two flops before the trigger logic sees them
        next_r.pin_meta = i_sync_pins;
        next_r.pin_sync = r.pin_meta;

        // one stage on pin triggers lines them up with the pin-to-wake figure
        next_r.pin_start_q = pin_start;
        next_r.pin_hop_q = pin_hop;

        next_r.ack = i_wr || i_rd;
        next_r.ack_start = '0;
        next_r.ack_hop = '0;

        // soft events wait in a short line so their latency is exact
        next_r.start_dly = {r.start_dly[`CSYNC_SOFT_START_DLY-2:0], r.ack_start};
        next_r.hop_dly = {r.hop_dly[`CSYNC_SOFT_HOP_DLY-2:0], r.ack_hop};

        // external word writes
        if (ext_hit(i_wr, i_ext, i_addr, `CSYNC_EXT_SLEEP)) begin
            // a cleared bit stays set until its start count ends
            next_r.sleep = r.sleep | i_wdata[N_CH-1:0];
            // a channel leaving sleep gets an internal start and hop
            next_r.ack_start = r.sleep & ~i_wdata[N_CH-1:0];
            next_r.ack_hop = r.sleep & ~i_wdata[N_CH-1:0];
        end else if (ext_hit(i_wr, i_ext, i_addr, `CSYNC_EXT_PIN)) begin
            next_r.pin_en = i_wdata[3:0];
            for (int c = 0; c < N_CH; c++) begin
                next_r.pin_ctl[c] = i_wdata[`CSYNC_PIN_FIRST_BIT:`CSYNC_PIN_START_BIT];
            end
        end else if (ext_hit(i_wr, i_ext, i_addr, `CSYNC_EXT_SOFT)) begin
            next_r.soft_word = i_wdata[5:0];
            for (int c = 0; c < N_CH; c++) begin
                next_r.soft_ctl[c] = i_wdata[`CSYNC_SOFT_HOP_BIT:`CSYNC_SOFT_START_BIT];
                next_r.ack_start[c] = i_wdata[`CSYNC_SOFT_START_BIT] && i_wdata[c];
                next_r.ack_hop[c] = i_wdata[`CSYNC_SOFT_HOP_BIT] && i_wdata[c];
            end
        end

        // channel register writes
        for (int c = 0; c < N_CH; c++) begin
            if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_SOFT)) begin
                next_r.soft_ctl[c] = i_wdata[`CSYNC_SOFT_HOP_BIT:`CSYNC_SOFT_START_BIT];
                next_r.ack_start[c] = i_wdata[`CSYNC_SOFT_START_BIT];
                next_r.ack_hop[c] = i_wdata[`CSYNC_SOFT_HOP_BIT];
            end else if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_PIN)) begin
                next_r.pin_ctl[c] = i_wdata[`CSYNC_PIN_FIRST_BIT:`CSYNC_PIN_START_BIT];
            end else if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_START_HOLD)) begin
                next_r.start_hold[c] = i_wdata[CNT_W-1:0];
            end else if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_FREQ_HOLD)) begin
                next_r.freq_hold[c] = i_wdata[CNT_W-1:0];
            end else if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_FREQ_LO)) begin
                next_r.freq_shadow[c][15:0] = i_wdata[15:0];
            end else if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_FREQ_HI)) begin
                next_r.freq_shadow[c][31:16] = i_wdata[15:0];
            end else if (ch_hit(i_wr, i_ext, i_chan, i_addr, c, `CSYNC_CH_SYNC_SEL)) begin
                next_r.sync_sel[c] = i_wdata[`CSYNC_SEL_LSB+1:`CSYNC_SEL_LSB];
            end
        end

        // counter results; hardware wakes win over a same-cycle sleep write
        for (int c = 0; c < N_CH; c++) begin
            if (next_r.sleep[c]) begin
                next_r.active[c] = 1'b0;
            end
            if (start_fire[c]) begin
                next_r.sleep[c] = 1'b0;
                next_r.active[c] = 1'b1;
            end
            // no sleep check here: hops apply to sleeping channels too
            if (hop_fire[c]) begin
                next_r.freq_work[c] = r.freq_shadow[c];
            end
        end

        // reads
        next_r.rdata = '0;
        if (i_rd && i_ext) begin
            if (i_addr == `CSYNC_EXT_SLEEP) begin
                next_r.rdata = 32'(r.sleep);
            end else if (i_addr == `CSYNC_EXT_PIN) begin
                next_r.rdata = {25'h0, r.pin_ctl[0], r.pin_en};
            end else if (i_addr == `CSYNC_EXT_SOFT) begin
                next_r.rdata = {26'h0, r.soft_word};
            end
        end else if (i_rd) begin
            if (i_addr == `CSYNC_CH_SOFT) begin
                next_r.rdata = {26'h0, r.soft_ctl[i_chan], 4'h0};
            end else if (i_addr == `CSYNC_CH_PIN) begin
                next_r.rdata = {25'h0, r.pin_ctl[i_chan], 4'h0};
            end else if (i_addr == `CSYNC_CH_START_HOLD) begin
                next_r.rdata = 32'(r.start_hold[i_chan]);
            end else if (i_addr == `CSYNC_CH_FREQ_HOLD) begin
                next_r.rdata = 32'(r.freq_hold[i_chan]);
            end else if (i_addr == `CSYNC_CH_FREQ_LO) begin
                next_r.rdata = {16'h0, r.freq_shadow[i_chan][15:0]};
            end else if (i_addr == `CSYNC_CH_FREQ_HI) begin
                next_r.rdata = {16'h0, r.freq_shadow[i_chan][31:16]};
            end else if (i_addr == `CSYNC_CH_SYNC_SEL) begin
                next_r.rdata = {23'h0, r.sync_sel[i_chan], 7'h0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= '0;
            r.sleep <= `CSYNC_SLEEP_RST;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_write_ack_output = r.ack;
    assign o_rdata = r.rdata;
    assign o_sleep = r.sleep;
    assign o_ch_active = r.active;
    assign o_nco_freq = r.freq_work;

endmodule : csync_top

// ==== test/csync_properties.sv ====
`timescale 1ns/10ps
`include "csync_defs.svh"
module csync_properties
    import csync_pkg::*;
#(
    parameter int N_CH = 4,
    parameter int CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_ext,
    input wire logic [1:0] i_chan,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_sync_pins,
    input wire logic o_write_ack_output,
    input wire logic [31:0] o_rdata,
    input wire logic [N_CH-1:0] o_sleep,
    input wire logic [N_CH-1:0] o_ch_active,
    input wire logic [N_CH*32-1:0] o_nco_freq
);
    typedef struct packed {
        logic [15:0] n_st;
        logic [15:0] n_hp;
        logic [1:0] sel;
        logic pin_q;
        logic [17:0] s_cnt;
        logic [17:0] s_want;
        logic [17:0] h_cnt;
        logic [17:0] h_want;
    } csync_chk_t;
    csync_chk_t st, next_st;
    logic wx, w0, clr, s_go, h_go, pin_up;
    assign wx = i_wr && i_ext;
    assign w0 = i_wr && !i_ext && i_chan == 2'h0;
    assign clr = wx && i_addr == `CSYNC_EXT_SLEEP && !i_wdata[0] && o_sleep[0];
    assign s_go = clr || (wx && i_addr == `CSYNC_EXT_SOFT && i_wdata[4] && i_wdata[0])
        || (w0 && i_addr == `CSYNC_CH_SOFT && i_wdata[4]);
    assign h_go = clr || (wx && i_addr == `CSYNC_EXT_SOFT && i_wdata[5] && i_wdata[0])
        || (w0 && i_addr == `CSYNC_CH_SOFT && i_wdata[5]);
    assign pin_up = i_sync_pins[st.sel] && !st.pin_q;
    ////////////////////////////////////////////////////////////////////////////
    // cycles since the last channel 0 trigger, and the figure a wake must hit
    always_comb begin
        next_st = st;
        next_st.pin_q = i_sync_pins[st.sel];
        if (w0 && i_addr == `CSYNC_CH_START_HOLD) next_st.n_st = i_wdata[15:0];
        if (w0 && i_addr == `CSYNC_CH_FREQ_HOLD) next_st.n_hp = i_wdata[15:0];
        if (w0 && i_addr == `CSYNC_CH_SYNC_SEL) next_st.sel = i_wdata[8:7];
        if (st.s_cnt != 18'h3FFFF) next_st.s_cnt = st.s_cnt + 18'h1;
        if (st.h_cnt != 18'h3FFFF) next_st.h_cnt = st.h_cnt + 18'h1;
        if (s_go || (pin_up && o_sleep[0])) begin
            next_st.s_cnt = 18'h1;
            next_st.s_want = {2'h0, st.n_st} + (s_go ? 18'h7 : 18'h4);
        end
        if (h_go || pin_up) begin
            next_st.h_cnt = 18'h1;
            next_st.h_want = {2'h0, st.n_hp} + (h_go ? 18'h8 : 18'h6);
        end
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) st <= '0;
        else st <= next_st;
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_ack_next: assert property ((i_wr || i_rd) |=> o_write_ack_output)
        else $error("ack missing after request");
    a_ack_cause: assert property (o_write_ack_output |-> $past(i_wr || i_rd))
        else $error("ack without request");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data outside a read");
    a_sleep_reset: assert property (disable iff (1'b0)
        (!i_nrst && $past(!i_nrst)) |-> (o_sleep == `CSYNC_SLEEP_RST && o_ch_active == '0))
        else $error("reset left a channel awake");
    a_awake_asleep: assert property ((o_ch_active & o_sleep) == '0)
        else $error("channel active while asleep");
    a_wake_pair: assert property ($rose(o_ch_active[0]) |-> $fell(o_sleep[0]))
        else $error("wake without sleep bit clearing");
    a_start_lat: assert property ($rose(o_ch_active[0]) |-> st.s_cnt == st.s_want)
        else $error("channel woke at the wrong cycle");
    a_hop_lat: assert property ($changed(o_nco_freq[31:0]) |-> st.h_cnt == st.h_want)
        else $error("frequency changed at the wrong cycle");
    c_wake: cover property ($rose(o_ch_active[0]));
    c_hop: cover property ($changed(o_nco_freq[31:0]));
    c_pin: cover property (pin_up && o_sleep[0]);
endmodule : csync_properties

// ==== test/csync_host.sv ====
`timescale 1ns/10ps
module csync_host (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic o_ext,
    output logic [1:0] o_chan,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic [3:0] o_pins
);
    initial begin
        {o_wr, o_rd, o_ext, o_chan, o_addr, o_wdata, o_pins} = '0;
    end
    // one access per call; on release wr and rd drop low and the other lines show the inverse of the last value
    task automatic req(input logic wr, input logic ext, input logic [1:0] chan,
            input logic [7:0] addr, input logic [31:0] data, output logic [31:0] rv);
        @(negedge i_clk);
        {o_wr, o_rd, o_ext, o_chan, o_addr, o_wdata} = {wr, !wr, ext, chan, addr, data};
        @(posedge i_clk);
        @(negedge i_clk);
        rv = i_rdata;
        {o_wr, o_rd, o_ext, o_chan, o_addr, o_wdata} = {2'h0, !ext, ~o_chan, ~addr, ~data};
    endtask : req
    // sync source: high for one cycle, then low long enough to be seen
    task automatic pulse(input int idx);
        @(negedge i_clk);
        o_pins[idx] = 1'h1;
        @(posedge i_clk);
        @(negedge i_clk);
        o_pins[idx] = 1'h0;
    endtask : pulse
endmodule : csync_host

// ==== test/tb.sv ====
`timescale 1ns/10ps
`include "csync_defs.svh"
module tb;
    typedef struct {int mode; int n; int lat;} csync_row_t;
    logic i_clk, i_nrst, i_wr, i_rd, i_ext, o_write_ack_output;
    logic [1:0] i_chan;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, rv;
    logic [3:0] i_sync_pins, o_sleep, o_ch_active;
    logic [127:0] o_nco_freq;
    int errors = 0, checks_done = 0, k;
    logic [1:0] ch = 2'h0;
    // soft ext word, soft channel word, sleep clear, pin: latency n+6 or n+3
    csync_row_t rows[4] = '{'{0, 1, 7}, '{1, 2, 8}, '{2, 5, 11}, '{3, 4, 7}};
    csync_top u_csync_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd),
        .i_ext(i_ext), .i_chan(i_chan), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_sync_pins(i_sync_pins), .o_write_ack_output(o_write_ack_output),
        .o_rdata(o_rdata), .o_sleep(o_sleep), .o_ch_active(o_ch_active),
        .o_nco_freq(o_nco_freq));
    csync_host u_csync_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
        .o_ext(i_ext), .o_chan(i_chan), .o_addr(i_addr), .o_wdata(i_wdata),
        .o_pins(i_sync_pins));
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic w(input logic e, input logic [7:0] a, input logic [31:0] d);
        u_csync_host.req(1'h1, e, ch, a, d, rv);
    endtask : w
    task automatic measure(input int which, output int cnt);
        logic [31:0] f0;
        f0 = o_nco_freq[31:0];
        cnt = 0;
        do begin
            @(posedge i_clk);
            cnt++;
            @(negedge i_clk);
        end while (cnt < 300 && (which == 0 ? o_ch_active[0] !== 1'h1
            : o_nco_freq[31:0] === f0));
    endtask : measure
    task automatic end_sim();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        #200000;
        errors++;
        end_sim();
    end
    initial begin
        i_nrst = 1'h0;
        repeat (12) @(posedge i_clk);
        @(negedge i_clk) i_nrst = 1'h1;
        check({o_ch_active, o_sleep}, 32'h0F);
        foreach (rows[r]) begin
            w(1'h1, `CSYNC_EXT_SLEEP, 32'hF);
            w(1'h0, `CSYNC_CH_START_HOLD, 32'(rows[r].n));
            case (rows[r].mode)
                0: w(1'h1, `CSYNC_EXT_SOFT, 32'h11);
                1: w(1'h0, `CSYNC_CH_SOFT, 32'h10);
                2: w(1'h1, `CSYNC_EXT_SLEEP, 32'hE);
                default: begin
                    w(1'h1, `CSYNC_EXT_PIN, 32'h11);
                    u_csync_host.pulse(0);
                end
            endcase
            measure(0, k);
            check(32'(k), 32'(rows[r].lat));
            check({o_ch_active, o_sleep}, 32'h1E);
        end
        w(1'h1, `CSYNC_EXT_SLEEP, 32'hF);
        w(1'h0, `CSYNC_CH_START_HOLD, 32'h0);
        w(1'h1, `CSYNC_EXT_SOFT, 32'h11);
        repeat (20) @(negedge i_clk);
        check({o_ch_active, o_sleep}, 32'h0F);
        w(1'h0, `CSYNC_CH_START_HOLD, 32'h3);
        w(1'h1, `CSYNC_EXT_SLEEP, 32'hE);
        repeat (15) @(negedge i_clk);
        w(1'h0, `CSYNC_CH_FREQ_HOLD, 32'h9);
        w(1'h0, `CSYNC_CH_FREQ_LO, 32'h5678);
        w(1'h0, `CSYNC_CH_FREQ_HI, 32'h1234);
        u_csync_host.req(1'h0, 1'h0, 2'h0, `CSYNC_CH_FREQ_HOLD, 32'h0, rv);
        check(rv, 32'h9);
        u_csync_host.req(1'h0, 1'h0, 2'h0, 8'h99, 32'h0, rv);
        check(rv, 32'h0);
        w(1'h1, `CSYNC_EXT_SOFT, 32'h21);
        measure(1, k);
        check(32'(k), 32'h10);
        check(o_nco_freq[31:0], 32'h12345678);
        check({o_ch_active, o_sleep}, 32'h1E);
        w(1'h0, `CSYNC_CH_SYNC_SEL, 32'h100);
        w(1'h1, `CSYNC_EXT_PIN, 32'h65);
        w(1'h0, `CSYNC_CH_FREQ_LO, 32'hAAAA);
        u_csync_host.pulse(0);
        repeat (20) @(negedge i_clk);
        check(o_nco_freq[31:0], 32'h12345678);
        u_csync_host.pulse(2);
        measure(1, k);
        check(32'(k), 32'hE);
        check(o_nco_freq[31:0], 32'h1234AAAA);
        w(1'h0, `CSYNC_CH_FREQ_LO, 32'hBBBB);
        u_csync_host.pulse(2);
        repeat (20) @(negedge i_clk);
        check(o_nco_freq[31:0], 32'h1234AAAA);
        w(1'h1, `CSYNC_EXT_PIN, 32'h25);
        w(1'h0, `CSYNC_CH_FREQ_LO, 32'hCCCC);
        u_csync_host.pulse(2);
        repeat (2) @(posedge i_clk);
        u_csync_host.pulse(2);
        measure(1, k);
        check(32'(k), 32'hE);
        check(o_nco_freq[31:0], 32'h1234CCCC);
        // channels 1 and 2 start from pins B and D; channel 0 watches C
        w(1'h1, `CSYNC_EXT_SLEEP, 32'hF);
        w(1'h1, `CSYNC_EXT_PIN, 32'h1A);
        for (int c = 1; c < 3; c++) begin
            ch = 2'(c);
            w(1'h0, `CSYNC_CH_START_HOLD, 32'h2);
            w(1'h0, `CSYNC_CH_SYNC_SEL, (c == 1) ? 32'h80 : 32'h180);
        end
        ch = 2'h0;
        u_csync_host.pulse(1);
        repeat (4) @(negedge i_clk);
        check({o_ch_active, o_sleep}, 32'h0F);
        @(negedge i_clk);
        check({o_ch_active, o_sleep}, 32'h2D);
        u_csync_host.pulse(3);
        repeat (8) @(negedge i_clk);
        check({o_ch_active, o_sleep}, 32'h69);
        @(negedge i_clk) i_nrst = 1'h0;
        repeat (2) @(negedge i_clk);
        check({o_ch_active, o_sleep}, 32'h0F);
        i_nrst = 1'h1;
        end_sim();
    end
endmodule : tb
bind csync_top csync_properties #(.N_CH(N_CH), .CNT_W(CNT_W)) u_csync_properties (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_ext(i_ext),
    .i_chan(i_chan), .i_addr(i_addr), .i_wdata(i_wdata), .i_sync_pins(i_sync_pins),
    .o_write_ack_output(o_write_ack_output), .o_rdata(o_rdata), .o_sleep(o_sleep),
    .o_ch_active(o_ch_active), .o_nco_freq(o_nco_freq));
